// [logic/pas_pkg.sv]
`default_nettype none

package pas_pkg;

	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFF_READBACK  = 8'h00;
	localparam logic [7:0] OFF_LATCH     = 8'h01;
	localparam logic [7:0] OFF_DIRECTION = 8'h02;
	localparam logic [7:0] OFF_RELOC     = 8'h03;
	localparam logic [7:0] OFF_PORT_FUNC = 8'h04;
	localparam logic [7:0] OFF_CH1_MODE  = 8'h05;
	localparam logic [7:0] OFF_CH1_IO    = 8'h06;
	localparam logic [7:0] OFF_CH1_CTRL  = 8'h07;
	localparam logic [7:0] OFF_FRT_CTRL  = 8'h08;
	localparam logic [7:0] OFF_SYNC_CTRL = 8'h09;

	// Field positions
	localparam int RELOC_CH1_A_BIT   = 0;
	localparam int PFC_CS3_EN_BIT    = 0;
	localparam int FRT_CKS_LO_BIT    = 0;
	localparam int FRT_CKS_HI_BIT    = 1;
	localparam int FRT_CAPB_IE_BIT   = 2;
	localparam int FRT_CAPC_IE_BIT   = 3;
	localparam int FRT_CMPB_OE_BIT   = 4;
	localparam int SYNC_H_LO_BIT     = 0;
	localparam int SYNC_H_HI_BIT     = 1;
	localparam int SYNC_V_LO_BIT     = 2;
	localparam int SYNC_V_HI_BIT     = 3;
	localparam int SYNC_CLAMP_OE_BIT = 4;
	localparam int SYNC_BLANK_OE_BIT = 5;

	// Pin numbers with alternate functions
	localparam int PIN7 = 7;
	localparam int PIN6 = 6;
	localparam int PIN5 = 5;
	localparam int PIN4 = 4;
	localparam int PIN3 = 3;

	// Reset values
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [3:0] RST_NIBBLE   = 4'h0;
	localparam logic [1:0] RST_CLR      = 2'h0;

	// Encodings of the channel 1, sync mode and timer clock fields
	localparam logic [3:0] MODE_NORMAL  = 4'h0;
	localparam logic [1:0] MODE_HI_01   = 2'h1;
	localparam logic [3:0] MODE_PWM1    = 4'h2;
	localparam logic [3:0] MODE_PWM2    = 4'h3;
	localparam logic [1:0] IO_LO_NONE   = 2'h0;
	localparam logic [1:0] IO_HI_OUT0   = 2'h0;
	localparam logic [1:0] IO_HI_OUT1   = 2'h1;
	localparam logic [1:0] IO_HI_CAPT   = 2'h2;
	localparam logic [1:0] CLR_PWM2_OFF = 2'h1;
	localparam logic [1:0] SYNC_MODE_FB = 2'h0;
	localparam logic [1:0] CKS_EXT      = 2'h3;

	// Channel 1 configuration as one carrier
	typedef struct packed {
		logic [3:0] timer_mode_field;
		logic [3:0] a_pin_io_code;
		logic [1:0] counter_clear_source;
	} pas_ch1_cfg_s;

	// Output function of the channel 1 A pin
	typedef enum logic [1:0] {
		FN_NONE,
		FN_COMPARE,
		FN_PWM1,
		FN_PWM2
	} pas_out_fn_e;

	// What pin 7 drives
	typedef enum logic [1:0] {
		P7_GENERAL,
		P7_CHIP_SELECT,
		P7_TIMER
	} pas_p7_sel_e;

endpackage

`default_nettype wire

// [logic/pas_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none

// One port pin driver: peripheral output wins, else general I/O
module pas_pin_cell (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic clk_en,
	input  wire logic periph_sel,
	input  wire logic periph_level,
	input  wire logic direction,
	input  wire logic latch,
	output var  logic pin_out,
	output var  logic pin_oe
);

	logic next_pin_out;
	logic next_pin_oe;

	// Peripheral drive takes the pin whatever the direction bit says
	always_comb begin
		if (periph_sel) begin
			next_pin_out = periph_level;
			next_pin_oe  = 1'b1;
		end else begin
			next_pin_out = latch;
			next_pin_oe  = direction;
		end
	end

	// Registered so the pad sees no combinational glitches
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else if (clk_en) begin
			pin_out <= next_pin_out;
			pin_oe  <= next_pin_oe;
		end
	end

endmodule

`default_nettype wire

// [logic/pas_pin_mux.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Eight-bit pin-level register, software cannot write it
// - Output bits read latch, input bits read pin
// - Resets to zero, then follows sampled pin levels
// - Pin 7 timer use needs relocation bit
// - Expanded mode with enable: pin 7 chip-select
// - Single-chip: timer output or direction-selected general
// - Decode compare, PWM1 and PWM2 output functions
// - Pin 7 feeds capture for mode and code
// - PWM mode 1 suppresses B compare output
// - Pin 6 direction selects input or output
// - Pin 6 feeds external clock when selected
// - Pin 6 feeds horizontal feedback on mode 00
// - Pin 5 direction selects input or output
// - Pin 5 feeds capture B, vertical feedback
// - Pin 4 clamp output or general I/O
// - Pin 4 feeds capture C when enabled
// - Pin 3 blank, compare-B, else general I/O
module pas_pin_mux
	import pas_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [7:0]  reg_rdata,
	// Operating mode strap level
	input  wire logic        expanded_bus_mode,
	// Pads
	input  wire logic [7:0]  pin_in,
	output var  logic [7:0]  pin_out,
	output var  logic [7:0]  pin_oe,
	// Peripheral output levels
	input  wire logic        chip_select3_out,
	input  wire logic        ch1_a_compare_level,
	input  wire logic        clamp_pulse_out,
	input  wire logic        composite_blank_out,
	input  wire logic        free_timer_compare_b_out,
	// Peripheral inputs fed from pins
	output var  logic        ch1_a_capture_in,
	output var  logic        free_timer_ext_clock_in,
	output var  logic        horizontal_feedback_in,
	output var  logic        vertical_feedback_in,
	output var  logic        free_timer_capture_b_in,
	output var  logic        free_timer_capture_c_in,
	// Channel 1 status toward the timer
	output var  logic [1:0]  ch1_a_output_function,
	output var  logic        ch1_b_output_suppress
);

	// Software-visible state
	logic [7:0]   port_output_latch;
	logic [7:0]   port_direction;
	logic [7:0]   timer_pin_relocation_ctrl;
	logic [7:0]   port_function_control;
	pas_ch1_cfg_s ch1_cfg;
	logic [7:0]   frt_ctrl;
	logic [7:0]   sync_ctrl;
	logic [7:0]   port_pin_level_readback;

	// Decoded controls
	logic         ch1_a_pin_relocate;
	logic         chip_select3_enable;
	logic         free_timer_clock_sel_hi;
	logic         free_timer_clock_sel_lo;
	logic         capture_b_irq_enable;
	logic         capture_c_irq_enable;
	logic         compare_b_output_enable;
	logic         sync_input_mode_hi;
	logic         sync_input_mode_lo;
	logic         vsync_input_mode_hi;
	logic         vsync_input_mode_lo;
	logic         clamp_output_enable;
	logic         blank_output_enable;

	pas_out_fn_e  next_out_fn;
	pas_p7_sel_e  p7_sel;
	logic         next_capture_a;
	logic [7:0]   periph_sel;
	logic [7:0]   periph_level;
	logic [7:0]   next_readback;
	logic [7:0]   next_rdata;

	// Routing conditions for peripheral inputs fed from pins
	logic         route_ext_clock;
	logic         route_h_feedback;
	logic         route_v_feedback;
	logic         route_capture_b;
	logic         route_capture_c;

	assign ch1_a_pin_relocate      = timer_pin_relocation_ctrl[RELOC_CH1_A_BIT];
	assign chip_select3_enable     = port_function_control[PFC_CS3_EN_BIT];
	assign free_timer_clock_sel_hi = frt_ctrl[FRT_CKS_HI_BIT];
	assign free_timer_clock_sel_lo = frt_ctrl[FRT_CKS_LO_BIT];
	assign capture_b_irq_enable    = frt_ctrl[FRT_CAPB_IE_BIT];
	assign capture_c_irq_enable    = frt_ctrl[FRT_CAPC_IE_BIT];
	assign compare_b_output_enable = frt_ctrl[FRT_CMPB_OE_BIT];
	assign sync_input_mode_hi      = sync_ctrl[SYNC_H_HI_BIT];
	assign sync_input_mode_lo      = sync_ctrl[SYNC_H_LO_BIT];
	assign vsync_input_mode_hi     = sync_ctrl[SYNC_V_HI_BIT];
	assign vsync_input_mode_lo     = sync_ctrl[SYNC_V_LO_BIT];
	assign clamp_output_enable     = sync_ctrl[SYNC_CLAMP_OE_BIT];
	assign blank_output_enable     = sync_ctrl[SYNC_BLANK_OE_BIT];

	// Input routing hangs on control bits only, never on the pad owner,
	// so a peripheral can watch a pin that another function drives;
	// the pin level itself is gated in once per enabled cycle below
	assign route_ext_clock  = free_timer_clock_sel_hi &&
	                          free_timer_clock_sel_lo;
	assign route_h_feedback = {sync_input_mode_hi, sync_input_mode_lo} ==
	                          SYNC_MODE_FB;
	assign route_v_feedback = {vsync_input_mode_hi, vsync_input_mode_lo} ==
	                          SYNC_MODE_FB;
	assign route_capture_b  = capture_b_irq_enable;
	assign route_capture_c  = capture_c_irq_enable;

	// Register writes; the readback offset has no write path at all
	// Direction bits cannot be read back, so software keeps its own copy
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port_output_latch         <= RST_BYTE;
			port_direction            <= RST_BYTE;
			timer_pin_relocation_ctrl <= RST_BYTE;
			port_function_control     <= RST_BYTE;
			ch1_cfg.timer_mode_field  <= RST_NIBBLE;
			ch1_cfg.a_pin_io_code     <= RST_NIBBLE;
			ch1_cfg.counter_clear_source <= RST_CLR;
			frt_ctrl                  <= RST_BYTE;
			sync_ctrl                 <= RST_BYTE;
		end else if (clk_en && reg_wr) begin
			unique case (reg_addr)
				OFF_LATCH: begin
					port_output_latch <= reg_wdata;
				end
				OFF_DIRECTION: begin
					port_direction <= reg_wdata;
				end
				OFF_RELOC: begin
					timer_pin_relocation_ctrl <= reg_wdata;
				end
				OFF_PORT_FUNC: begin
					port_function_control <= reg_wdata;
				end
				OFF_CH1_MODE: begin
					ch1_cfg.timer_mode_field <= reg_wdata[3:0];
				end
				OFF_CH1_IO: begin
					ch1_cfg.a_pin_io_code <= reg_wdata[3:0];
				end
				OFF_CH1_CTRL: begin
					ch1_cfg.counter_clear_source <= reg_wdata[1:0];
				end
				OFF_FRT_CTRL: begin
					frt_ctrl <= reg_wdata;
				end
				OFF_SYNC_CTRL: begin
					sync_ctrl <= reg_wdata;
				end
				default: begin
					// Readback and unmapped offsets ignore writes
				end
			endcase
		end
	end

	// Channel 1 A-pin output function decode
	always_comb begin
		logic [3:0] md;
		logic [3:0] io;
		logic       normal;
		md     = ch1_cfg.timer_mode_field;
		io     = ch1_cfg.a_pin_io_code;
		normal = (md == MODE_NORMAL) || (md[3:2] == MODE_HI_01);
		next_out_fn = FN_NONE;
		if (normal && io[1:0] != IO_LO_NONE &&
		    (io[3:2] == IO_HI_OUT0 || io[3:2] == IO_HI_OUT1)) begin
			next_out_fn = FN_COMPARE;
		end else if (md == MODE_PWM1 && io[1:0] != IO_LO_NONE) begin
			next_out_fn = FN_PWM1;
		end else if (md == MODE_PWM2 && io[1:0] != IO_LO_NONE &&
		             ch1_cfg.counter_clear_source != CLR_PWM2_OFF) begin
			next_out_fn = FN_PWM2;
		end
		// Capture only through the relocated pin; PWM modes leave the
		// pin an output, so they never qualify
		next_capture_a = ch1_a_pin_relocate && normal &&
		                 io[3:2] == IO_HI_CAPT;
	end

	// Pin 7 owner; chip select overrides timer in expanded mode
	// With relocation off the timer has no pad, so chip select or direction decides
	always_comb begin
		if (expanded_bus_mode && chip_select3_enable) begin
			p7_sel = P7_CHIP_SELECT;
		end else if (ch1_a_pin_relocate && next_out_fn != FN_NONE) begin
			p7_sel = P7_TIMER;
		end else begin
			p7_sel = P7_GENERAL;
		end
	end

	// Per-pin peripheral drive selection and level
	always_comb begin
		periph_sel   = 8'h00;
		periph_level = 8'h00;
		unique case (p7_sel)
			P7_CHIP_SELECT: begin
				periph_sel[PIN7]   = 1'b1;
				periph_level[PIN7] = chip_select3_out;
			end
			P7_TIMER: begin
				periph_sel[PIN7]   = 1'b1;
				periph_level[PIN7] = ch1_a_compare_level;
			end
			P7_GENERAL: begin
				periph_sel[PIN7]   = 1'b0;
			end
		endcase
		// Pins 6 and 5 only ever drive as general outputs
		periph_sel[PIN6] = 1'b0;
		periph_sel[PIN5] = 1'b0;
		periph_sel[PIN4]   = clamp_output_enable;
		periph_level[PIN4] = clamp_pulse_out;
		if (blank_output_enable) begin
			periph_sel[PIN3]   = 1'b1;
			periph_level[PIN3] = composite_blank_out;
		end else if (compare_b_output_enable) begin
			periph_sel[PIN3]   = 1'b1;
			periph_level[PIN3] = free_timer_compare_b_out;
		end
	end

	// Pad drivers, one cell per pin; pins 2..0 stay general I/O
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			pas_pin_cell u_cell (
				.sys_clk      (sys_clk),
				.rst_b        (rst_b),
				.clk_en       (clk_en),
				.periph_sel   (periph_sel[gi]),
				.periph_level (periph_level[gi]),
				.direction    (port_direction[gi]),
				.latch        (port_output_latch[gi]),
				.pin_out      (pin_out[gi]),
				.pin_oe       (pin_oe[gi])
			);
		end
	endgenerate

	// Routed inputs watch the pad level even while a peripheral drives it
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ch1_a_capture_in        <= 1'b0;
			free_timer_ext_clock_in <= 1'b0;
			horizontal_feedback_in  <= 1'b0;
			vertical_feedback_in    <= 1'b0;
			free_timer_capture_b_in <= 1'b0;
			free_timer_capture_c_in <= 1'b0;
		end else if (clk_en) begin
			ch1_a_capture_in <= next_capture_a && pin_in[PIN7];
			free_timer_ext_clock_in <= route_ext_clock && pin_in[PIN6];
			horizontal_feedback_in <= route_h_feedback && pin_in[PIN6];
			vertical_feedback_in <= route_v_feedback && pin_in[PIN5];
			free_timer_capture_b_in <= route_capture_b && pin_in[PIN5];
			free_timer_capture_c_in <= route_capture_c && pin_in[PIN4];
		end
	end

	// Channel status back to the timer
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ch1_a_output_function <= FN_NONE;
		end else if (clk_en) begin
			ch1_a_output_function <= next_out_fn;
		end
	end

	// The B compare pin must stay quiet in PWM mode 1, whether or not
	// the A pin is relocated, since the channel owns both pins
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ch1_b_output_suppress <= 1'b0;
		end else if (clk_en) begin
			ch1_b_output_suppress <= (next_out_fn == FN_PWM1);
		end
	end

	// Pin-level image: output bits show the latch, input bits the pad
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			next_readback[i] = port_direction[i] ? port_output_latch[i]
			                                     : pin_in[i];
		end
	end

	// Tracks the pads every enabled cycle; the reset zero lasts until the first enabled edge after reset
	// Registering the image keeps pad glitches out of the read path
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port_pin_level_readback <= RST_BYTE;
		end else if (clk_en) begin
			port_pin_level_readback <= next_readback;
		end
	end

	// Read mux; direction is write-only and reads zero
	always_comb begin
		unique case (reg_addr)
			OFF_READBACK:  next_rdata = port_pin_level_readback;
			OFF_LATCH:     next_rdata = port_output_latch;
			OFF_RELOC:     next_rdata = timer_pin_relocation_ctrl;
			OFF_PORT_FUNC: next_rdata = port_function_control;
			OFF_CH1_MODE:  next_rdata = {4'h0, ch1_cfg.timer_mode_field};
			OFF_CH1_IO:    next_rdata = {4'h0, ch1_cfg.a_pin_io_code};
			OFF_CH1_CTRL:  next_rdata = {6'h00, ch1_cfg.counter_clear_source};
			OFF_FRT_CTRL:  next_rdata = frt_ctrl;
			OFF_SYNC_CTRL: next_rdata = sync_ctrl;
			default:       next_rdata = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end

endmodule

`default_nettype wire

// [tb/pas_pad_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Board pads and the on-chip peripherals that feed port pins
module pas_pad_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] ext_lvl,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output wire logic [7:0] pin_in,
	output wire logic       chip_select3_out,
	output wire logic       ch1_a_compare_level,
	output wire logic       clamp_pulse_out,
	output wire logic       composite_blank_out,
	output wire logic       free_timer_compare_b_out
);
	logic [4:0] lvl;

	// A driven pad reads the port's level, an idle one the board's
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	// Levels keep moving so a stale or wrong pick shows on the pad
	always_ff @(posedge sys_clk) begin
		lvl <= rst_b ? lvl + 5'h0b : 5'h15;
	end
	assign {chip_select3_out, ch1_a_compare_level, clamp_pulse_out,
		composite_blank_out, free_timer_compare_b_out} = lvl;
endmodule

`default_nettype wire

// [tb/pas_pin_mux_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

// Shadows the control registers off the write strobe and checks the pads
module pas_pin_mux_monitor
	import pas_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic       clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       expanded_bus_mode,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic       chip_select3_out,
	input wire logic       ch1_a_compare_level,
	input wire logic       clamp_pulse_out,
	input wire logic       composite_blank_out,
	input wire logic       free_timer_compare_b_out,
	input wire logic       ch1_a_capture_in,
	input wire logic       free_timer_ext_clock_in,
	input wire logic       horizontal_feedback_in,
	input wire logic       vertical_feedback_in,
	input wire logic       free_timer_capture_b_in,
	input wire logic       free_timer_capture_c_in,
	input wire logic [1:0] ch1_a_output_function,
	input wire logic       ch1_b_output_suppress
);
	logic [7:0] dir, lat, frt, syn, x_oe, x_out, x_drv, x_rb;
	logic [3:0] md, io;
	logic [1:0] clr, cnt, fn;
	logic [5:0] x_rt;
	logic       rel, pfc, arm, cs, tim, pick, act, pwm1;

	// Shadow state; offset 00 and unmapped offsets take no write
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			{dir, lat, frt, syn, rel, pfc} <= 34'h0;
			{md, io, clr, cnt} <= 12'h000;
		end else begin
			cnt <= !clk_en ? 2'h0 : arm ? cnt : cnt + 2'h1;
			if (reg_wr && clk_en) begin
				case (reg_addr)
					OFF_LATCH:     lat <= reg_wdata;
					OFF_DIRECTION: dir <= reg_wdata;
					OFF_RELOC:     rel <= reg_wdata[0];
					OFF_PORT_FUNC: pfc <= reg_wdata[0];
					OFF_CH1_MODE:  md <= reg_wdata[3:0];
					OFF_CH1_IO:    io <= reg_wdata[3:0];
					OFF_CH1_CTRL:  clr <= reg_wdata[1:0];
					OFF_FRT_CTRL:  frt <= reg_wdata;
					OFF_SYNC_CTRL: syn <= reg_wdata;
					default: ;
				endcase
			end
		end
	end
	// Waits out reset and frozen cycles, whose history $past still sees
	assign arm = cnt == 2'h3;

	// Expected selections; the design registers them once more
	always_comb begin
		pick = md == MODE_NORMAL || md[3:2] == MODE_HI_01;
		act = io[1:0] != IO_LO_NONE;
		fn = 2'h0;
		if (pick && !io[3] && act)
			fn = 2'h1;
		else if (md == MODE_PWM1 && act)
			fn = 2'h2;
		else if (md == MODE_PWM2 && act && clr != CLR_PWM2_OFF)
			fn = 2'h3;
		pwm1 = fn == 2'h2;
		cs = expanded_bus_mode & pfc;
		tim = rel && fn != 2'h0;
		x_oe = {cs | tim | dir[7], dir[6:5], syn[4] | dir[4],
			syn[5] | frt[4] | dir[3], dir[2:0]};
		x_out = {cs ? chip_select3_out : tim ? ch1_a_compare_level : lat[7],
			lat[6:5], syn[4] ? clamp_pulse_out : lat[4],
			syn[5] ? composite_blank_out :
			frt[4] ? free_timer_compare_b_out : lat[3], lat[2:0]};
		x_drv = x_out & x_oe;
		x_rt = {pin_in[7] & rel & pick & (io[3:2] == IO_HI_CAPT),
			pin_in[6] & (frt[1:0] == CKS_EXT),
			pin_in[6] & (syn[1:0] == SYNC_MODE_FB),
			pin_in[5] & (syn[3:2] == SYNC_MODE_FB),
			pin_in[5] & frt[2], pin_in[4] & frt[3]};
		x_rb = (dir & lat) | (~dir & pin_in);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_rb_read;
		arm && clk_en && reg_rd && reg_addr == OFF_READBACK;
	endsequence

	chk_readback_value: assert property (
		s_rb_read |=> reg_rdata == $past(x_rb, 2)) else $error("readback");
	chk_pad_enable: assert property (
		arm |-> pin_oe == $past(x_oe)) else $error("pad enable");
	chk_pad_level: assert property (
		arm |-> (pin_out & pin_oe) == $past(x_drv)) else $error("pad level");
	chk_out_function: assert property (
		arm |-> ch1_a_output_function == $past(fn)) else $error("function");
	chk_b_suppress: assert property (
		arm |-> ch1_b_output_suppress == $past(pwm1)) else $error("suppress");
	chk_capture_a: assert property (
		arm |-> ch1_a_capture_in == $past(x_rt[5])) else $error("capture a");
	chk_ext_clock: assert property (
		arm |-> free_timer_ext_clock_in == $past(x_rt[4]))
		else $error("ext clock");
	chk_sync_feedback: assert property (
		arm |-> {horizontal_feedback_in, vertical_feedback_in} ==
		$past(x_rt[3:2])) else $error("feedback");
	chk_capture_bc: assert property (
		arm |-> {free_timer_capture_b_in, free_timer_capture_c_in} ==
		$past(x_rt[1:0])) else $error("capture b c");
endmodule

bind pas_pin_mux pas_pin_mux_monitor u_pas_pin_mux_monitor (.*);

`default_nettype wire

// [tb/tb_pas_pin_mux.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_pas_pin_mux
	import pas_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        clk_en = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        expanded_bus_mode = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  ext_lvl = 8'h00;
	logic [7:0]  reg_rdata, pin_in, pin_out, pin_oe, rv, d, l, e;
	logic [1:0]  ch1_a_output_function;
	logic        chip_select3_out, ch1_a_compare_level, clamp_pulse_out;
	logic        composite_blank_out, free_timer_compare_b_out;
	logic        ch1_a_capture_in, free_timer_ext_clock_in;
	logic        horizontal_feedback_in, vertical_feedback_in;
	logic        free_timer_capture_b_in, free_timer_capture_c_in;
	logic        ch1_b_output_suppress;
	logic        rd_seen = 1'b0;
	logic [31:0] t;
	logic [7:0]  exp_q[$];
	int          fail_count = 0;
	int          n_compared = 0;
	int          i;
	integer      seed = 32'hcb1800fc;
	// Pin 7: {expanded,cs3 en,relocate,dir}, mode, io, clear, oe7, function
	logic [23:0] tbl[11] = '{24'h201011, 24'h245011, 24'h204000, 24'h222012,
		24'h228000, 24'h233013, 24'h233100, 24'h236213, 24'h001001,
		24'hc01011, 24'hb08010};
	// Pins 6 to 3: timer ctrl, sync ctrl, pad enables, routed inputs
	logic [31:0] sel[2] = '{32'h1f2f0813, 32'h1010180c};

	pas_pin_mux u_pas_pin_mux (.*);
	pas_pad_model u_pas_pad_model (.*);

	// 125 MHz system clock
	always #4 sys_clk = ~sys_clk;
	assign rv = {3'h0, free_timer_ext_clock_in, horizontal_feedback_in,
		vertical_feedback_in, free_timer_capture_b_in, free_timer_capture_c_in};

	task automatic check(input string nm, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done;
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One bus cycle; each call assigns every strobe exactly once
	task automatic cyc(input logic w, r, input logic [7:0] a, dt);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= dt;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, dt);
		cyc(1'b1, 1'b0, a, dt);
	endtask

	task automatic rd(input logic [7:0] a, x);
		exp_q.push_back(x);
		cyc(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic idle;
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen)
			check("reg_rdata", reg_rdata, exp_q.pop_front());
		else if (rst_b)
			check("reg_rdata idle", reg_rdata, 8'h00);
		rd_seen <= reg_rd;
	end

	// A hang counts as a failure
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		test_done;
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		e = 8'($random(seed));
		ext_lvl <= e;
		repeat (3) idle;
		rd(OFF_READBACK, e);
		// Direction picks latch or pad; writes to the readback are lost
		for (i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			l = 8'($random(seed));
			e = 8'($random(seed));
			ext_lvl <= e;
			wr(OFF_DIRECTION, d);
			wr(OFF_LATCH, l);
			wr(OFF_READBACK, ~l);
			idle;
			rd(OFF_READBACK, (d & l) | (~d & e));
			rd(OFF_LATCH, l);
			rd(OFF_DIRECTION, 8'h00);
			rd(8'h0a, 8'h00);
		end
		// A low clock enable freezes state: this latch write is lost
		clk_en <= 1'b0;
		wr(OFF_LATCH, ~l);
		clk_en <= 1'b1;
		rd(OFF_LATCH, l);
		// Pin 7 modes, codes and chip select
		for (i = 0; i < 11; i++) begin
			t = {8'h00, tbl[i]};
			expanded_bus_mode <= t[23];
			wr(OFF_PORT_FUNC, {7'h00, t[22]});
			wr(OFF_RELOC, {7'h00, t[21]});
			wr(OFF_DIRECTION, {t[20], 7'h00});
			wr(OFF_CH1_MODE, {4'h0, t[19:16]});
			wr(OFF_CH1_IO, {4'h0, t[15:12]});
			wr(OFF_CH1_CTRL, {4'h0, t[11:8]});
			idle;
			idle;
			check("pin_oe7", {7'h00, pin_oe[7]}, {7'h00, t[4]});
			check("function", {6'h00, ch1_a_output_function},
				{4'h0, t[3:0]});
			check("suppress", {7'h00, ch1_b_output_suppress},
				{7'h00, t[1:0] == 2'h2});
		end
		// Pins 6 to 3 with their timer and sync functions
		wr(OFF_DIRECTION, 8'h00);
		ext_lvl <= 8'hff;
		for (i = 0; i < 2; i++) begin
			t = sel[i];
			wr(OFF_FRT_CTRL, t[31:24]);
			wr(OFF_SYNC_CTRL, t[23:16]);
			idle;
			idle;
			check("pin_oe", pin_oe, t[15:8]);
			check("routed", rv, t[7:0]);
		end
		// Random configurations and pad levels for the checker
		repeat (300) begin
			ext_lvl <= 8'($random(seed));
			expanded_bus_mode <= 1'($random(seed));
			clk_en <= 2'($random(seed)) != 2'h0;
			cyc(1'b1, 1'b0, 8'($random(seed)) & 8'h0f, 8'($random(seed)));
		end
		clk_en <= 1'b1;
		idle;
		idle;
		test_done;
	end
endmodule

`default_nettype wire
